// ### core/pam_port_a_mux.sv
// Port A direction control and pin function selection with APB registers.
// Assumes i_rst is the power-on reset; manual reset and low-power modes
// never reach these registers, so their contents survive them.
//
// Design decisions made here: the address map and register access over APB.
`default_nettype none
module pam_port_a_mux
	import pam_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic i_clock, // 40 MHz system clock
	input wire logic i_rst, // Power-on reset, active high
	input wire logic i_clk_en, // Freezes all state when low
	// APB slave
	input wire logic i_psel, // Slave select
	input wire logic i_penable, // Access phase
	input wire logic i_pwrite, // Write when high
	input wire logic [ADDR_W-1:0] i_paddr, // Byte address
	input wire logic [31:0] i_pwdata, // Write data
	input wire logic [3:0] i_pstrb, // Byte lane strobes
	output logic [31:0] o_prdata, // Read data
	output logic o_pready, // Transfer complete
	output logic o_pslverr, // Unmapped address
	// Pins
	input wire logic [15:0] i_pin, // Pad input levels
	output logic [15:0] o_pin, // Pad output levels
	output logic [15:0] o_pin_oe, // Pad output enables, high drives
	// Peripheral inputs taken from pins
	output logic [3:0] o_interrupt_request_input, // Levels for 3..0
	output logic o_dma_request_input_ch1, // Pin 15 level
	output logic o_dma_request_input_ch0, // Pin 13 level
	output logic o_timer_external_clock_b, // Pin 13 level
	output logic o_timer_external_clock_a, // Pin 12 level
	output logic o_upper_bus_parity, // Pin 11 level
	output logic o_lower_bus_parity, // Pin 10 level
	output logic o_timer_ch1_capture_compare_b, // Pin 11 level
	output logic o_timer_ch1_capture_compare_a, // Pin 10 level
	output logic o_timer_ch0_capture_compare_b, // Pin 2 level
	output logic o_timer_ch0_capture_compare_a, // Pin 0 level
	output logic o_external_bus_request, // Pin 8 level
	output logic [7:0] o_lower_fn_in, // Pins 7..0 in function use
	// Peripheral outputs onto pins
	input wire logic i_dma_acknowledge_output_ch1, // To pin 14
	input wire logic i_dma_acknowledge_output_ch0, // To pin 12
	input wire logic i_upper_parity_out, // To pin 11
	input wire logic i_upper_parity_oe, // Parity drive enable
	input wire logic i_lower_parity_out, // To pin 10
	input wire logic i_lower_parity_oe, // Parity drive enable
	input wire logic i_tcc1_b_out, // Timer 1 compare B to pin 11
	input wire logic i_tcc1_a_out, // Timer 1 compare A to pin 10
	input wire logic i_tcc0_b_out, // Timer 0 compare B to pin 2
	input wire logic i_tcc0_a_out, // Timer 0 compare A to pin 0
	input wire logic i_address_hold_output, // To pin 9
	input wire logic i_interrupt_request_output, // To pin 9
	input wire logic [7:0] i_lower_fn_out, // Bus functions, pins 7..0
	input wire logic [7:0] i_lower_fn_oe // Their drive enables
);
	logic [15:0] port_a_pin_direction;
	logic [15:0] port_a_upper_function_select;
	logic [15:0] port_a_lower_function_select;
	logic [15:0] port_data;
	logic [15:0] pin_level;
	logic wr_en;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic hit_dir;
	logic hit_upper;
	logic hit_lower;
	logic hit_data;
	logic hit_level;
	logic hit_any;
	logic [15:0] rd_word;
	logic [3:0] next_irq;
	logic next_dma_request_input_ch1;
	logic next_dma_request_input_ch0;
	logic next_timer_external_clock_b;
	logic next_timer_external_clock_a;
	logic next_par_hi;
	logic next_par_lo;
	logic next_tcc1_b;
	logic next_tcc1_a;
	logic next_tcc0_b;
	logic next_tcc0_a;
	logic next_external_bus_request;
	logic [7:0] next_lower_in;

	pam_pad_if #(.WIDTH(16)) pif ();

	pam_sync #(.WIDTH(16)) u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_async(i_pin),
		.o_sync(pin_level)
	);

	pam_pad_drive u_drive (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.pif(pif.drv)
	);

	assign o_pin = pif.pin_o;
	assign o_pin_oe = pif.pin_oe;

	// Address decode; an unaligned address matches nothing
	always_comb begin
		hit_dir = (i_paddr == ADDR_W'(PAM_OFF_DIR));
		hit_upper = (i_paddr == ADDR_W'(PAM_OFF_UPPER));
		hit_lower = (i_paddr == ADDR_W'(PAM_OFF_LOWER));
		hit_data = (i_paddr == ADDR_W'(PAM_OFF_DATA));
		hit_level = (i_paddr == ADDR_W'(PAM_OFF_LEVEL));
		hit_any = hit_dir | hit_upper | hit_lower | hit_data | hit_level;
	end

	// A stalled clock enable stretches the access instead of losing it
	assign o_pready = i_clk_en;
	assign o_pslverr = i_psel & i_penable & ~hit_any;
	assign wr_en = i_psel & i_penable & i_pwrite & i_clk_en;
	assign wmask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
	assign wval = i_pwdata[15:0];

	always_comb begin
		rd_word = '0;
		if (hit_dir) begin
			rd_word = port_a_pin_direction;
		end else if (hit_upper) begin
			rd_word = port_a_upper_function_select | PAM_ONES_UPPER;
		end else if (hit_lower) begin
			rd_word = port_a_lower_function_select | PAM_ONES_LOWER;
		end else if (hit_data) begin
			rd_word = port_data;
		end else if (hit_level) begin
			rd_word = pin_level;
		end
		o_prdata = (i_psel & ~i_pwrite) ? {16'h0000, rd_word} : 32'h00000000;
	end

	// Only power-on reset clears this; nothing else re-initialises it
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			port_a_pin_direction <= PAM_RST_DIR;
		end else if (wr_en && hit_dir) begin
			port_a_pin_direction <= (port_a_pin_direction & ~wmask)
				| (wval & wmask);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			port_a_upper_function_select <= PAM_RST_UPPER;
		end else if (wr_en && hit_upper) begin
			// Stuck bit is kept at one whatever software writes
			port_a_upper_function_select <= ((port_a_upper_function_select
				& ~wmask) | (wval & wmask)) | PAM_ONES_UPPER;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			port_a_lower_function_select <= PAM_RST_LOWER;
		end else if (wr_en && hit_lower) begin
			port_a_lower_function_select <= ((port_a_lower_function_select
				& ~wmask) | (wval & wmask)) | PAM_ONES_LOWER;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			port_data <= PAM_RST_DATA;
		end else if (wr_en && hit_data) begin
			port_data <= (port_data & ~wmask) | (wval & wmask);
		end
	end

	// Upper pins, fields of the upper select register
	always_comb begin
		pif.use_dir = '1;
		pif.dir = port_a_pin_direction;
		pif.dir_data = port_data;
		pif.fn_out = '0;
		pif.fn_oe = '0;
		next_irq = '0;
		next_dma_request_input_ch1 = 1'b0;
		next_dma_request_input_ch0 = 1'b0;
		next_timer_external_clock_b = 1'b0;
		next_timer_external_clock_a = 1'b0;
		next_par_hi = 1'b0;
		next_par_lo = 1'b0;
		next_tcc1_b = 1'b0;
		next_tcc1_a = 1'b0;
		next_tcc0_b = 1'b0;
		next_tcc0_a = 1'b0;
		next_external_bus_request = 1'b0;
		next_lower_in = '0;
		// Reserved codes fall to default and stay in port use
		unique case (port_a_upper_function_select[PAM_F15_LSB +: 2])
			PAM_MD_FN2: begin
				pif.use_dir[15] = 1'b0;
				next_irq[3] = pin_level[15];
			end
			PAM_MD_FN4: begin
				pif.use_dir[15] = 1'b0;
				next_dma_request_input_ch1 = pin_level[15];
			end
			default: ;
		endcase
		unique case (port_a_upper_function_select[PAM_F14_LSB +: 2])
			PAM_MD_FN2: begin
				pif.use_dir[14] = 1'b0;
				next_irq[2] = pin_level[14];
			end
			PAM_MD_FN4: begin
				pif.use_dir[14] = 1'b0;
				pif.fn_out[14] = i_dma_acknowledge_output_ch1;
				pif.fn_oe[14] = 1'b1;
			end
			default: ;
		endcase
		unique case (port_a_upper_function_select[PAM_F13_LSB +: 2])
			PAM_MD_PORT: ;
			PAM_MD_FN2: begin
				pif.use_dir[13] = 1'b0;
				next_irq[1] = pin_level[13];
			end
			PAM_MD_FN3: begin
				pif.use_dir[13] = 1'b0;
				next_timer_external_clock_b = pin_level[13];
			end
			PAM_MD_FN4: begin
				pif.use_dir[13] = 1'b0;
				next_dma_request_input_ch0 = pin_level[13];
			end
		endcase
		unique case (port_a_upper_function_select[PAM_F12_LSB +: 2])
			PAM_MD_PORT: ;
			PAM_MD_FN2: begin
				pif.use_dir[12] = 1'b0;
				next_irq[0] = pin_level[12];
			end
			PAM_MD_FN3: begin
				pif.use_dir[12] = 1'b0;
				next_timer_external_clock_a = pin_level[12];
			end
			PAM_MD_FN4: begin
				pif.use_dir[12] = 1'b0;
				pif.fn_out[12] = i_dma_acknowledge_output_ch0;
				pif.fn_oe[12] = 1'b1;
			end
		endcase
		// Capture/compare keeps direction control, data comes from timer
		unique case (port_a_upper_function_select[PAM_F11_LSB +: 2])
			PAM_MD_FN2: begin
				pif.use_dir[11] = 1'b0;
				pif.fn_out[11] = i_upper_parity_out;
				pif.fn_oe[11] = i_upper_parity_oe;
				next_par_hi = pin_level[11];
			end
			PAM_MD_FN3: begin
				pif.dir_data[11] = i_tcc1_b_out;
				next_tcc1_b = pin_level[11];
			end
			default: ;
		endcase
		unique case (port_a_upper_function_select[PAM_F10_LSB +: 2])
			PAM_MD_FN2: begin
				pif.use_dir[10] = 1'b0;
				pif.fn_out[10] = i_lower_parity_out;
				pif.fn_oe[10] = i_lower_parity_oe;
				next_par_lo = pin_level[10];
			end
			PAM_MD_FN3: begin
				pif.dir_data[10] = i_tcc1_a_out;
				next_tcc1_a = pin_level[10];
			end
			default: ;
		endcase
		unique case (port_a_upper_function_select[PAM_F9_LSB +: 2])
			PAM_MD_FN2: begin
				pif.use_dir[9] = 1'b0;
				pif.fn_out[9] = i_address_hold_output;
				pif.fn_oe[9] = 1'b1;
			end
			PAM_MD_FN4: begin
				pif.use_dir[9] = 1'b0;
				pif.fn_out[9] = i_interrupt_request_output;
				pif.fn_oe[9] = 1'b1;
			end
			default: ;
		endcase
		if (port_a_upper_function_select[PAM_F8_BIT]) begin
			pif.use_dir[8] = 1'b0;
			next_external_bus_request = pin_level[8];
		end
		// Lower pins: single-bit fields hand the pin to the bus functions
		for (int p = 4; p < 8; p++) begin
			if (port_a_lower_function_select[2 * p - PAM_F4_BIT + 8]) begin
				pif.use_dir[p] = 1'b0;
				pif.fn_out[p] = i_lower_fn_out[p];
				pif.fn_oe[p] = i_lower_fn_oe[p];
				next_lower_in[p] = pin_level[p];
			end
		end
		for (int p = 0; p < 4; p++) begin
			unique case (port_a_lower_function_select[2 * p +: 2])
				PAM_MD_FN2: begin
					pif.use_dir[p] = 1'b0;
					pif.fn_out[p] = i_lower_fn_out[p];
					pif.fn_oe[p] = i_lower_fn_oe[p];
					next_lower_in[p] = pin_level[p];
				end
				PAM_MD_FN3: begin
					if (p == 0) begin
						pif.dir_data[0] = i_tcc0_a_out;
						next_tcc0_a = pin_level[0];
					end else if (p == 2) begin
						pif.dir_data[2] = i_tcc0_b_out;
						next_tcc0_b = pin_level[2];
					end else begin
						pif.use_dir[p] = 1'b0;
						pif.fn_out[p] = i_lower_fn_out[p];
						pif.fn_oe[p] = i_lower_fn_oe[p];
						next_lower_in[p] = pin_level[p];
					end
				end
				default: ;
			endcase
		end
	end

	// Unselected functions see a quiet zero, never a stray pin level
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_interrupt_request_input <= '0;
			o_dma_request_input_ch1 <= 1'b0;
			o_dma_request_input_ch0 <= 1'b0;
			o_timer_external_clock_b <= 1'b0;
			o_timer_external_clock_a <= 1'b0;
			o_upper_bus_parity <= 1'b0;
			o_lower_bus_parity <= 1'b0;
			o_timer_ch1_capture_compare_b <= 1'b0;
			o_timer_ch1_capture_compare_a <= 1'b0;
			o_timer_ch0_capture_compare_b <= 1'b0;
			o_timer_ch0_capture_compare_a <= 1'b0;
			o_external_bus_request <= 1'b0;
			o_lower_fn_in <= '0;
		end else if (i_clk_en) begin
			o_interrupt_request_input <= next_irq;
			o_dma_request_input_ch1 <= next_dma_request_input_ch1;
			o_dma_request_input_ch0 <= next_dma_request_input_ch0;
			o_timer_external_clock_b <= next_timer_external_clock_b;
			o_timer_external_clock_a <= next_timer_external_clock_a;
			o_upper_bus_parity <= next_par_hi;
			o_lower_bus_parity <= next_par_lo;
			o_timer_ch1_capture_compare_b <= next_tcc1_b;
			o_timer_ch1_capture_compare_a <= next_tcc1_a;
			o_timer_ch0_capture_compare_b <= next_tcc0_b;
			o_timer_ch0_capture_compare_a <= next_tcc0_a;
			o_external_bus_request <= next_external_bus_request;
			o_lower_fn_in <= next_lower_in;
		end
	end
endmodule : pam_port_a_mux
`default_nettype wire

// ### core/pam_pkg.sv
// Constants shared by the port A direction and function-select block.
// Assumes a 40 MHz clock, a power-on reset on i_rst and an APB master.
// Function
// - Direction bits act only in port use or timer capture/compare use.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register clears on power-on reset only.
// - Upper and lower select load 3302 and FF95 on power-on reset only.
// - Upper select serves pins 15 to 8, lower select pins 7 to 0.
// - Pin 15: port, interrupt input 3, reserved, DMA request 1.
// - Pin 14: port, interrupt input 2, reserved, DMA acknowledge 1.
// - Pin 13: port, interrupt input 1, timer clock B, DMA request 0.
// - Pin 12: port, interrupt input 0, timer clock A, DMA acknowledge 0.
// - Pin 11: port, upper parity, timer 1 capture/compare B, reserved.
// - Pin 10: port, lower parity, timer 1 capture/compare A, reserved.
// - Pin 9: port, address hold, reserved, interrupt request output.
// - Upper select bit 1 always reads 1; software writes it as 1.
// - Pin 8: port, or external bus request input.
`default_nettype none
package pam_pkg;
	localparam logic [11:0] PAM_OFF_DIR = 12'h000;
	localparam logic [11:0] PAM_OFF_UPPER = 12'h004;
	localparam logic [11:0] PAM_OFF_LOWER = 12'h008;
	localparam logic [11:0] PAM_OFF_DATA = 12'h00C;
	localparam logic [11:0] PAM_OFF_LEVEL = 12'h010;
	localparam logic [15:0] PAM_RST_DIR = 16'h0000;
	localparam logic [15:0] PAM_RST_UPPER = 16'h3302;
	localparam logic [15:0] PAM_RST_LOWER = 16'hFF95;
	localparam logic [15:0] PAM_RST_DATA = 16'h0000;
	// Reserved bits that are stuck at one
	localparam logic [15:0] PAM_ONES_UPPER = 16'h0002;
	localparam logic [15:0] PAM_ONES_LOWER = 16'hAA00;
	// Field positions, upper select
	localparam int PAM_F15_LSB = 14;
	localparam int PAM_F14_LSB = 12;
	localparam int PAM_F13_LSB = 10;
	localparam int PAM_F12_LSB = 8;
	localparam int PAM_F11_LSB = 6;
	localparam int PAM_F10_LSB = 4;
	localparam int PAM_F9_LSB = 2;
	localparam int PAM_F8_BIT = 0;
	// Field positions, lower select
	localparam int PAM_F7_BIT = 14;
	localparam int PAM_F6_BIT = 12;
	localparam int PAM_F5_BIT = 10;
	localparam int PAM_F4_BIT = 8;
	localparam int PAM_F3_LSB = 6;
	localparam int PAM_F2_LSB = 4;
	localparam int PAM_F1_LSB = 2;
	localparam int PAM_F0_LSB = 0;
	// Two-bit selection codes
	localparam logic [1:0] PAM_MD_PORT = 2'h0;
	localparam logic [1:0] PAM_MD_FN2 = 2'h1;
	localparam logic [1:0] PAM_MD_FN3 = 2'h2;
	localparam logic [1:0] PAM_MD_FN4 = 2'h3;
	localparam int PAM_SYNC_STAGES = 3;
endpackage : pam_pkg
`default_nettype wire

// ### core/pam_pad_if.sv
// Per-pin drive request passed from the selector to the pad driver.
// Assumes one clock domain; all vectors are one bit per pin.
`default_nettype none
interface pam_pad_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] use_dir;
	logic [WIDTH-1:0] dir;
	logic [WIDTH-1:0] dir_data;
	logic [WIDTH-1:0] fn_out;
	logic [WIDTH-1:0] fn_oe;
	logic [WIDTH-1:0] pin_o;
	logic [WIDTH-1:0] pin_oe;
	modport ctl (output use_dir, dir, dir_data, fn_out, fn_oe,
		input pin_o, pin_oe);
	modport drv (input use_dir, dir, dir_data, fn_out, fn_oe,
		output pin_o, pin_oe);
endinterface : pam_pad_if
`default_nettype wire

// ### core/pam_sync.sv
// Three-stage synchroniser for pin inputs.
// Assumes asynchronous inputs; a bit changes once stages two and three agree.
`default_nettype none
module pam_sync #(
	parameter int WIDTH = 16
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst, // Power-on reset, active high
	input wire logic i_clk_en, // Freezes all state when low
	input wire logic [WIDTH-1:0] i_async, // Raw pin levels
	output logic [WIDTH-1:0] o_sync // Filtered levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else if (i_clk_en) begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Only stages two and three are compared, never the first
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_sync <= '0;
		end else if (i_clk_en) begin
			for (int b = 0; b < WIDTH; b++) begin
				if (stage2[b] == stage3[b]) begin
					o_sync[b] <= stage3[b];
				end
			end
		end
	end
endmodule : pam_sync
`default_nettype wire

// ### core/pam_pad_drive.sv
// Registered pad driver: picks direction-controlled or function drive.
// Assumes the selector fills the interface from the same clock.
`default_nettype none
module pam_pad_drive (
	input wire logic i_clock, // System clock
	input wire logic i_rst, // Power-on reset, active high
	input wire logic i_clk_en, // Freezes all state when low
	pam_pad_if.drv pif // Drive request and pad result
);
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pif.pin_o <= '0;
			pif.pin_oe <= '0;
		end else if (i_clk_en) begin
			for (int b = 0; b < $bits(pif.pin_o); b++) begin
				if (pif.use_dir[b]) begin
					pif.pin_oe[b] <= pif.dir[b];
					pif.pin_o[b] <= pif.dir_data[b];
				end else begin
					pif.pin_oe[b] <= pif.fn_oe[b];
					pif.pin_o[b] <= pif.fn_out[b];
				end
			end
		end
	end
endmodule : pam_pad_drive
`default_nettype wire

// ### tb/pam_port_a_mux_sva.sv
// Checker for the port A direction and upper function-select block.
// Assumes one clock domain and an APB master that holds each request.
`default_nettype none
module pam_port_a_mux_chk
	import pam_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst, // Power-on reset
	input wire logic i_psel, // Select
	input wire logic i_penable, // Access phase
	input wire logic i_pwrite, // Write
	input wire logic [ADDR_W-1:0] i_paddr, // Byte address
	input wire logic [31:0] i_pwdata, // Write data
	input wire logic [3:0] i_pstrb, // Lane strobes
	input wire logic [31:0] o_prdata, // Read data
	input wire logic o_pready, // Ready
	input wire logic [15:0] o_pin, // Pad data
	input wire logic [15:0] o_pin_oe, // Pad enables
	input wire logic i_dma_acknowledge_output_ch1, // To pin 14
	input wire logic i_dma_acknowledge_output_ch0, // To pin 12
	input wire logic i_lower_parity_oe, // Pin 10 enable
	input wire logic i_address_hold_output // To pin 9
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sh_up;
	logic rst_d;
	logic [15:0] sh_dir;
	logic [15:0] m;
	logic up_wr;
	logic dir_wr;
	logic wr;
	logic rd_up;
	logic rd_dir;
	assign m = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
	assign wr = i_psel && i_penable && i_pwrite && o_pready;
	assign rd_up = i_psel && !i_pwrite && i_paddr == PAM_OFF_UPPER;
	assign rd_dir = i_psel && !i_pwrite && i_paddr == PAM_OFF_DIR;
	default clocking @(posedge i_clock); endclocking
	// Reset is released on a clock edge; the attempt started at that edge
	// would judge flops still held in reset, so checks wait one more edge
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rst_d <= 1'b1;
		end else begin
			rst_d <= 1'b0;
		end
	end
	default disable iff (i_rst || rst_d);
	// Mirrors follow the lanes, so partial writes are judged correctly
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sh_up <= 16'h3302;
			up_wr <= 1'b0;
		end else if (wr && i_paddr == PAM_OFF_UPPER) begin
			sh_up <= (sh_up & ~m) | (i_pwdata[15:0] & m);
			up_wr <= 1'b1;
		end
	end
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sh_dir <= 16'h0000;
			dir_wr <= 1'b0;
		end else if (wr && i_paddr == PAM_OFF_DIR) begin
			sh_dir <= (sh_dir & ~m) | (i_pwdata[15:0] & m);
			dir_wr <= 1'b1;
		end
	end
	dir_reset_a: assert property (
		rd_dir && !dir_wr |-> o_prdata[15:0] == 16'h0000)
		else $error("direction register lost its reset value");
	upper_reset_a: assert property (
		rd_up && !up_wr |-> o_prdata[15:0] == 16'h3302)
		else $error("upper select lost its reset value");
	resv_one_a: assert property (rd_up |-> o_prdata[1])
		else $error("upper select bit 1 read as 0");
	port_dir_a: assert property (
		!sh_up[14] |=> o_pin_oe[15] == $past(sh_dir[15]))
		else $error("pin 15 enable ignores direction");
	p15_in_a: assert property (sh_up[14] |=> !o_pin_oe[15])
		else $error("pin 15 driven in input use");
	dma_acknowledge_output_ch1_a: assert property (
		sh_up[13:12] == PAM_MD_FN4 |=> o_pin_oe[14]
		&& o_pin[14] == $past(i_dma_acknowledge_output_ch1))
		else $error("pin 14 does not carry acknowledge 1");
	dma_acknowledge_output_ch0_a: assert property (
		sh_up[9:8] == PAM_MD_FN4 |=> o_pin_oe[12]
		&& o_pin[12] == $past(i_dma_acknowledge_output_ch0))
		else $error("pin 12 does not carry acknowledge 0");
	p13_in_a: assert property (
		sh_up[11:10] != PAM_MD_PORT |=> !o_pin_oe[13])
		else $error("pin 13 driven in input use");
	timer_dir_a: assert property (
		sh_up[7:6] == PAM_MD_FN3 |=> o_pin_oe[11] == $past(sh_dir[11]))
		else $error("pin 11 timer use ignores direction");
	parity_oe_a: assert property (
		sh_up[5:4] == PAM_MD_FN2 |=> o_pin_oe[10] == $past(i_lower_parity_oe))
		else $error("pin 10 parity enable wrong");
	hold_out_a: assert property (
		sh_up[3:2] == PAM_MD_FN2 |=> o_pin_oe[9]
		&& o_pin[9] == $past(i_address_hold_output))
		else $error("pin 9 does not carry address hold");
	external_bus_request_in_a: assert property (sh_up[0] |=> !o_pin_oe[8])
		else $error("pin 8 driven in bus request use");
endmodule // pam_port_a_mux_chk
bind pam_port_a_mux pam_port_a_mux_chk #(.ADDR_W(ADDR_W)) i_chk (
	.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
	.i_pstrb, .o_prdata, .o_pready, .o_pin, .o_pin_oe,
	.i_dma_acknowledge_output_ch1, .i_dma_acknowledge_output_ch0,
	.i_lower_parity_oe, .i_address_hold_output);
`default_nettype wire

// ### tb/pam_far_pins.sv
// Outside world at the port A pads, resolved against the block's drive.
// Assumes the bench sets what the outside drives; no pin has a pull.
`default_nettype none
module pam_far_pins (
	input wire logic [15:0] i_ext, // Level driven from outside
	input wire logic [15:0] i_out, // Block pad data
	input wire logic [15:0] i_oe, // Block pad enables
	output logic [15:0] o_level // Level seen on the pad
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside drivers are weak, so an enabled block pad always wins
	assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // pam_far_pins
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the port A direction and function-select block.
// Assumes a 40 MHz clock and one APB transfer at a time.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pam_pkg::*;
	localparam logic [7:0] FIX_OE [4] = '{8'h00, 8'h0E, 8'h00, 8'h52};
	localparam logic [7:0] DIR_M [4] = '{8'hFF, 8'h00, 8'hCF, 8'h0C};
	localparam logic [7:0] E_OUT [4] = '{8'hA5, 8'h0A, 8'h89, 8'h56};
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic en = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0;
	logic [3:0] strb = 4'h3;
	logic [15:0] ext = 16'hFFFF;
	logic [11:0] fn = 12'h000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] pin;
	logic [15:0] pin_o;
	logic [15:0] pin_oe;
	logic [12:0] pi;
	int error_cnt = 0;
	int checked = 0;
	pam_port_a_mux #(.ADDR_W(12)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_clk_en(en), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wdat), .i_pstrb(strb), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_pin(pin), .o_pin(pin_o),
		.o_pin_oe(pin_oe), .o_interrupt_request_input(pi[12:9]),
		.o_dma_request_input_ch1(pi[8]), .o_dma_request_input_ch0(pi[7]),
		.o_timer_external_clock_b(pi[6]), .o_timer_external_clock_a(pi[5]),
		.o_upper_bus_parity(pi[4]), .o_lower_bus_parity(pi[3]),
		.o_timer_ch1_capture_compare_b(pi[2]),
		.o_timer_ch1_capture_compare_a(pi[1]),
		.o_timer_ch0_capture_compare_b(), .o_timer_ch0_capture_compare_a(),
		.o_external_bus_request(pi[0]), .o_lower_fn_in(),
		.i_dma_acknowledge_output_ch1(fn[0]),
		.i_dma_acknowledge_output_ch0(fn[1]), .i_upper_parity_out(fn[2]),
		.i_upper_parity_oe(fn[3]), .i_lower_parity_out(fn[4]),
		.i_lower_parity_oe(fn[5]), .i_tcc1_b_out(fn[6]), .i_tcc1_a_out(fn[7]),
		.i_tcc0_b_out(fn[8]), .i_tcc0_a_out(fn[9]),
		.i_address_hold_output(fn[10]), .i_interrupt_request_output(fn[11]),
		.i_lower_fn_out(8'h00), .i_lower_fn_oe(8'h00));
	pam_far_pins i_far (.i_ext(ext), .i_out(pin_o), .i_oe(pin_oe),
		.o_level(pin));
	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge i_clock);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge i_clock);
		pen <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge i_clock);
		end while (pready !== 1'b1);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {16'h0, d}, r, e);
	endtask
	task automatic rd(input string what, input logic [11:0] a,
		input logic [15:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, {16'h0, x}, r);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	initial begin
		repeat (5000) @(posedge i_clock);
		error_cnt++;
		$display("BAD watchdog expected done seen hang");
		summarize();
	end
	initial begin
		logic [7:0] eo;
		logic [7:0] lvl;
		logic [12:0] ep;
		logic [15:0] d;
		logic [31:0] r;
		logic e;
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
		rd("dir", PAM_OFF_DIR, 16'h0000);
		rd("upper", PAM_OFF_UPPER, 16'h3302);
		rd("lower", PAM_OFF_LOWER, 16'hFF95);
		chk("oe reset", 32'h50, {24'h0, pin_oe[15:8]});
		$display("test reset_values done");
		wr(PAM_OFF_UPPER, 16'h0002);
		wr(PAM_OFF_DATA, 16'hA500);
		wr(PAM_OFF_DIR, 16'hFF00);
		tick(2);
		chk("oe out", 32'hFF, {24'h0, pin_oe[15:8]});
		chk("pin out", 32'hA5, {24'h0, pin_o[15:8]});
		ext <= 16'h3CFF;
		wr(PAM_OFF_DIR, 16'h0000);
		tick(8);
		chk("oe in", 32'h0, {24'h0, pin_oe[15:8]});
		rd("level", PAM_OFF_LEVEL, 16'h3CFF);
		wr(PAM_OFF_UPPER, 16'h0002);
		rd("upper bit1", PAM_OFF_UPPER, 16'h0002);
		$display("test direction done");
		ext <= 16'hFFFF;
		fn <= 12'hC6F;
		for (int k = 0; k < 8; k++) begin
			logic [1:0] c;
			c = k[1:0];
			d = k[2] ? 16'h0000 : 16'hFFFF;
			wr(PAM_OFF_DIR, d);
			// Reserved codes go in on purpose to see the pins stay in port use
			wr(PAM_OFF_UPPER, {{7{c}}, 1'b1, c[0]});
			tick(8);
			eo = FIX_OE[c] | (DIR_M[c] & d[15:8]);
			lvl = (eo & E_OUT[c]) | ~eo;
			ep = {(c == 2'h1) ? 4'hF : 4'h0, c == 2'h3, c == 2'h3, c == 2'h2,
				c == 2'h2, c == 2'h1 && lvl[3], c == 2'h1 && lvl[2],
				c == 2'h2 && lvl[3], c == 2'h2 && lvl[2], c[0] && lvl[0]};
			chk("fn oe", {24'h0, eo}, {24'h0, pin_oe[15:8]});
			chk("fn pin", {24'h0, E_OUT[c] & eo}, {24'h0, pin_o[15:8] & eo});
			chk("fn in", {19'h0, ep}, {19'h0, pi});
			$display("test function code %0d dir %h done", c, d);
		end
		apb(1'b0, 12'h014, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		// Non-zero direction so the second reset visibly clears it
		wr(PAM_OFF_DIR, 16'h1234);
		i_rst <= 1'b1;
		tick(3);
		i_rst <= 1'b0;
		rd("dir again", PAM_OFF_DIR, 16'h0000);
		rd("upper again", PAM_OFF_UPPER, 16'h3302);
		$display("test second_reset done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
